/* rtl/lpd_top.sv */
// LPDDR command, power-state and mode register model with AHB-Lite status
//
// What this block does
// - Power moves use current and previous CKE
// - CKE fall picks power-down, self refresh, deep
// - Mode load with BA 00 writes standard
// - Standard mode kept until reload, deep sleep
// - Mode load leaves array contents untouched
// - Reads and writes burst at programmed length
// - Burst lengths 2, 4, 8, 16 supported
// - CAS latency 2 or 3 clocks
// - Mode load with BA 10 writes extended
`timescale 1ns/1ps
module lpd_top (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire lpd_pkg::lpd_pins_t memPins,
  output logic      [2:0]         powerState,
  output logic                    readBurst,
  output logic                    writeBurst,
  output logic                    initDone
);

  lpd_pkg::lpd_pins_t pinS;
  lpd_pkg::lpd_pwr_t  pwr_q, pwr_d;
  lpd_pkg::lpd_cmd_t  cmd;
  logic        clkPrev_q, linkRise;
  logic        ckePrev_q, ckePrev_d;
  logic [3:0]  bankOpen_q, bankOpen_d;
  logic [1:0]  rdLat_q, rdLat_d;
  logic [3:0]  rdLeft_q, rdLeft_d;
  logic [3:0]  wrLeft_q, wrLeft_d;
  logic [6:0]  stdMode_q, stdMode_d;
  logic [12:0] extMode_q, extMode_d;
  logic        stdLoaded_q, stdLoaded_d;
  logic        extLoaded_q, extLoaded_d;
  logic [1:0]  refCnt_q, refCnt_d;
  logic        rsvd_q, rsvd_d;
  logic        init_q, init_d;
  logic        rdOut_d, wrOut_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  logic [31:0] hrdata_d, rdVal;
  logic        busTake;

  // All pins, link clock included, share one delay so they stay aligned
  lpd_sync #(.WIDTH($bits(lpd_pkg::lpd_pins_t))) uSync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (memPins),
    .dout     (pinS)
  );

  assign linkRise = pinS.memClk & ~clkPrev_q;
  assign cmd      = lpd_pkg::decodeCmd(pinS);

  always_comb
  begin
    pwr_d       = pwr_q;
    ckePrev_d   = ckePrev_q;
    bankOpen_d  = bankOpen_q;
    rdLat_d     = rdLat_q;
    rdLeft_d    = rdLeft_q;
    wrLeft_d    = wrLeft_q;
    stdMode_d   = stdMode_q;
    extMode_d   = extMode_q;
    stdLoaded_d = stdLoaded_q;
    extLoaded_d = extLoaded_q;
    refCnt_d    = refCnt_q;
    rsvd_d      = rsvd_q;
    if (linkRise)
    begin
      ckePrev_d = pinS.cke;
      if (rdLat_q != 2'h0)
        rdLat_d = rdLat_q - 2'h1;
      else if (rdLeft_q != 4'h0)
        rdLeft_d = rdLeft_q - 4'h1;
      if (wrLeft_q != 4'h0)
        wrLeft_d = wrLeft_q - 4'h1;
      unique case (pwr_q)
        lpd_pkg::PW_NORMAL:
        begin
          if (ckePrev_q && !pinS.cke)
          begin
            if (cmd == lpd_pkg::CMD_NOP)
              pwr_d = (|bankOpen_q) ? lpd_pkg::PW_ACT_PD
                                    : lpd_pkg::PW_PRE_PD;
            else if (!(|bankOpen_q) && cmd == lpd_pkg::CMD_AREF)
              pwr_d = lpd_pkg::PW_SELF_REFRESH;
            else if (!(|bankOpen_q) && cmd == lpd_pkg::CMD_BST)
            begin
              // Deep sleep loses both mode registers
              pwr_d       = lpd_pkg::PW_DEEPEST_SLEEP_STATE;
              stdMode_d   = lpd_pkg::STD_MODE_RESET;
              extMode_d   = lpd_pkg::EXT_MODE_RESET;
              stdLoaded_d = 1'b0;
              extLoaded_d = 1'b0;
              refCnt_d    = 2'h0;
              bankOpen_d  = 4'h0;
              rdLat_d     = 2'h0;
              rdLeft_d    = 4'h0;
              wrLeft_d    = 4'h0;
            end
          end
          else if (ckePrev_q && ctrl_q[lpd_pkg::CTRL_EN_BIT])
          begin
            unique case (cmd)
              lpd_pkg::CMD_NOP: ;
              lpd_pkg::CMD_ACT:
                bankOpen_d[pinS.ba] = 1'b1;
              lpd_pkg::CMD_READ:
              begin
                rdLat_d  = lpd_pkg::casLat(stdMode_q);
                rdLeft_d = lpd_pkg::blHalf(stdMode_q);
                wrLeft_d = 4'h0;
                // Concurrent auto precharge frees the bank at once
                if (pinS.addr[lpd_pkg::AP_BIT])
                  bankOpen_d[pinS.ba] = 1'b0;
              end
              lpd_pkg::CMD_WRITE:
              begin
                wrLeft_d = lpd_pkg::blHalf(stdMode_q);
                rdLat_d  = 2'h0;
                rdLeft_d = 4'h0;
                if (pinS.addr[lpd_pkg::AP_BIT])
                  bankOpen_d[pinS.ba] = 1'b0;
              end
              lpd_pkg::CMD_BST:
              begin
                rdLat_d  = 2'h0;
                rdLeft_d = 4'h0;
              end
              lpd_pkg::CMD_PRE:
                if (pinS.addr[lpd_pkg::AP_BIT])
                  bankOpen_d = 4'h0;
                else
                  bankOpen_d[pinS.ba] = 1'b0;
              lpd_pkg::CMD_AREF:
                if (refCnt_q != lpd_pkg::REF_NEEDED)
                  refCnt_d = refCnt_q + 2'h1;
              lpd_pkg::CMD_LMR:
              begin
                // Only mode state changes; no array is touched
                if (pinS.ba == lpd_pkg::BA_STD)
                begin
                  stdMode_d   = pinS.addr[6:0];
                  stdLoaded_d = 1'b1;
                  rsvd_d      = |pinS.addr[12:lpd_pkg::MR_OP_LSB];
                end
                else if (pinS.ba == lpd_pkg::BA_EXT)
                begin
                  extMode_d   = pinS.addr;
                  extLoaded_d = 1'b1;
                end
              end
            endcase
          end
        end
        default:
        begin
          // Exit only on CKE rise with NOP; anything else holds
          if (!ckePrev_q && pinS.cke && cmd == lpd_pkg::CMD_NOP)
            pwr_d = lpd_pkg::PW_NORMAL;
        end
      endcase
    end
    init_d  = stdLoaded_d & extLoaded_d &
              (refCnt_d == lpd_pkg::REF_NEEDED);
    rdOut_d = (rdLat_d == 2'h0) && (rdLeft_d != 4'h0);
    wrOut_d = (wrLeft_d != 4'h0);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clkPrev_q   <= 1'b0;
      pwr_q       <= lpd_pkg::PW_NORMAL;
      ckePrev_q   <= 1'b1;
      bankOpen_q  <= 4'h0;
      rdLat_q     <= 2'h0;
      rdLeft_q    <= 4'h0;
      wrLeft_q    <= 4'h0;
      stdMode_q   <= lpd_pkg::STD_MODE_RESET;
      extMode_q   <= lpd_pkg::EXT_MODE_RESET;
      stdLoaded_q <= 1'b0;
      extLoaded_q <= 1'b0;
      refCnt_q    <= 2'h0;
      rsvd_q      <= 1'b0;
      init_q      <= 1'b0;
      readBurst   <= 1'b0;
      writeBurst  <= 1'b0;
    end
    else
    begin
      clkPrev_q   <= pinS.memClk;
      pwr_q       <= pwr_d;
      ckePrev_q   <= ckePrev_d;
      bankOpen_q  <= bankOpen_d;
      rdLat_q     <= rdLat_d;
      rdLeft_q    <= rdLeft_d;
      wrLeft_q    <= wrLeft_d;
      stdMode_q   <= stdMode_d;
      extMode_q   <= extMode_d;
      stdLoaded_q <= stdLoaded_d;
      extLoaded_q <= extLoaded_d;
      refCnt_q    <= refCnt_d;
      rsvd_q      <= rsvd_d;
      init_q      <= init_d;
      readBurst   <= rdOut_d;
      writeBurst  <= wrOut_d;
    end
  end

  assign powerState = pwr_q;
  assign initDone   = init_q;

  // Bus: zero wait states, read data registered at the address phase
  assign busTake = hsel & htrans[1] & hready;

  always_comb
  begin
    rdVal = 32'h0000_0000;
    unique case (haddr[7:0])
      lpd_pkg::ADDR_STATUS:
      begin
        rdVal[lpd_pkg::ST_PWR_LSB +: 3]  = pwr_q;
        rdVal[lpd_pkg::ST_BANK_LSB +: 4] = bankOpen_q;
        rdVal[lpd_pkg::ST_RD_BIT]        = readBurst;
        rdVal[lpd_pkg::ST_WR_BIT]        = writeBurst;
        rdVal[lpd_pkg::ST_INIT_BIT]      = init_q;
        rdVal[lpd_pkg::ST_RSVD_BIT]      = rsvd_q;
      end
      lpd_pkg::ADDR_STD_MODE: rdVal[6:0]  = stdMode_q;
      lpd_pkg::ADDR_EXT_MODE: rdVal[12:0] = extMode_q;
      lpd_pkg::ADDR_CONTROL:
        // Forward a write still in its data phase
        rdVal = (wrPend_q && wrAddr_q == lpd_pkg::ADDR_CONTROL)
                ? hwdata : ctrl_q;
      lpd_pkg::ADDR_TIMING:
      begin
        rdVal[lpd_pkg::TM_BLH_LSB +: 4] = lpd_pkg::blHalf(stdMode_q);
        rdVal[lpd_pkg::TM_CL_LSB +: 2]  = lpd_pkg::casLat(stdMode_q);
        rdVal[lpd_pkg::TM_BT_BIT]       = stdMode_q[lpd_pkg::MR_BT_BIT];
      end
      default: rdVal = 32'h0000_0000;
    endcase
    ctrl_d   = ctrl_q;
    if (wrPend_q && wrAddr_q == lpd_pkg::ADDR_CONTROL)
      ctrl_d = hwdata;
    wrPend_d = busTake & hwrite;
    wrAddr_d = busTake ? haddr[7:0] : wrAddr_q;
    hrdata_d = (busTake && !hwrite) ? rdVal : 32'h0000_0000;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q    <= lpd_pkg::CTRL_RESET;
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      wrPend_q  <= wrPend_d;
      wrAddr_q  <= wrAddr_d;
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : lpd_top

/* rtl/lpd_pkg.sv */
// Shared types, register map and mode decoding for the LPDDR command model
package lpd_pkg;

  typedef struct packed {
    logic        memClk;
    logic        cke;
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic [1:0]  ba;
    logic [12:0] addr;
  } lpd_pins_t;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
    CMD_BST, CMD_PRE, CMD_AREF, CMD_LMR
  } lpd_cmd_t;

  typedef enum logic [2:0] {
    PW_NORMAL, PW_ACT_PD, PW_PRE_PD, PW_SELF_REFRESH,
    PW_DEEPEST_SLEEP_STATE
  } lpd_pwr_t;

  // Bank address {BA1,BA0} selecting the mode register target
  localparam logic [1:0]  BA_STD          = 2'b00;
  localparam logic [1:0]  BA_EXT          = 2'b10;
  localparam int          AP_BIT          = 10;
  // Standard mode register fields
  localparam int          MR_BL_LSB       = 0;
  localparam int          MR_BT_BIT       = 3;
  localparam int          MR_CL_LSB       = 4;
  localparam int          MR_OP_LSB       = 7;
  localparam logic [2:0]  BL_2            = 3'h1;
  localparam logic [2:0]  BL_4            = 3'h2;
  localparam logic [2:0]  BL_8            = 3'h3;
  localparam logic [2:0]  BL_16           = 3'h4;
  localparam logic [2:0]  CL_2            = 3'h2;
  localparam logic [2:0]  CL_3            = 3'h3;
  localparam logic [6:0]  STD_MODE_RESET  = 7'h00;
  localparam logic [12:0] EXT_MODE_RESET  = 13'h0000;
  // Register byte offsets
  localparam logic [7:0]  ADDR_STATUS     = 8'h00;
  localparam logic [7:0]  ADDR_STD_MODE   = 8'h04;
  localparam logic [7:0]  ADDR_EXT_MODE   = 8'h08;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h0c;
  localparam logic [7:0]  ADDR_TIMING     = 8'h10;
  // Status fields
  localparam int          ST_PWR_LSB      = 0;
  localparam int          ST_BANK_LSB     = 4;
  localparam int          ST_RD_BIT       = 8;
  localparam int          ST_WR_BIT       = 9;
  localparam int          ST_INIT_BIT     = 10;
  localparam int          ST_RSVD_BIT     = 11;
  // Timing fields
  localparam int          TM_BLH_LSB      = 0;
  localparam int          TM_CL_LSB       = 8;
  localparam int          TM_BT_BIT       = 12;
  // Control fields
  localparam int          CTRL_EN_BIT     = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam logic [1:0]  REF_NEEDED      = 2'h2;

  // Burst length in link clocks (half the beats), zero when reserved
  function automatic logic [3:0] blHalf(input logic [6:0] mode);
    unique case (mode[MR_BL_LSB +: 3])
      BL_2:    blHalf = 4'h1;
      BL_4:    blHalf = 4'h2;
      BL_8:    blHalf = 4'h4;
      BL_16:   blHalf = 4'h8;
      default: blHalf = 4'h0;
    endcase
  endfunction : blHalf

  function automatic logic [1:0] casLat(input logic [6:0] mode);
    unique case (mode[MR_CL_LSB +: 3])
      CL_2:    casLat = 2'h2;
      CL_3:    casLat = 2'h3;
      default: casLat = 2'h0;
    endcase
  endfunction : casLat

  function automatic lpd_cmd_t decodeCmd(input lpd_pins_t p);
    if (p.csN)
      decodeCmd = CMD_NOP;
    else
      unique case ({p.rasN, p.casN, p.weN})
        3'h7:    decodeCmd = CMD_NOP;
        3'h3:    decodeCmd = CMD_ACT;
        3'h5:    decodeCmd = CMD_READ;
        3'h4:    decodeCmd = CMD_WRITE;
        3'h6:    decodeCmd = CMD_BST;
        3'h2:    decodeCmd = CMD_PRE;
        3'h1:    decodeCmd = CMD_AREF;
        default: decodeCmd = CMD_LMR;
      endcase
  endfunction : decodeCmd

endpackage : lpd_pkg

/* rtl/lpd_sync.sv */
// Two-flop synchroniser for the memory-side pins
`timescale 1ns/1ps
module lpd_sync #(
  parameter int WIDTH = 21
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : lpd_sync

/* testbench/lpd_top_sva.sv */
// Port checker for lpd_top
`timescale 1ns/1ps
module lpd_top_sva (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire lpd_pkg::lpd_pins_t memPins,
  input wire logic [2:0]         powerState,
  input wire logic               readBurst,
  input wire logic               writeBurst,
  input wire logic               initDone
);
  logic       clkPrev_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  logic [3:0] low_q;
  logic [3:0] low_d;
  // Saturating, so long idle gaps never wrap round
  always_comb
  begin
    age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
    if (memPins.memClk && !clkPrev_q)
      age_d = 4'h0;
    low_d = (low_q == 4'hf) ? low_q : low_q + 4'h1;
    if (memPins.cke)
      low_d = 4'h0;
  end
  always_ff @(posedge core_clk)
  begin
    clkPrev_q <= rst ? 1'b0 : memPins.memClk;
    age_q     <= rst ? 4'hf : age_d;
    low_q     <= rst ? 4'h0 : low_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence deepHeld;
    powerState == 3'h4 ##1 powerState == 3'h4;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_ready_after_reset: assert property (!rst |=> hreadyout)
    else $error("hreadyout low");
  a_rdata_read_only: assert property (hrdata != 32'h0 |->
    $past(hsel && htrans[1] && !hwrite && hready))
    else $error("hrdata outside read");
  a_power_legal: assert property (powerState <= 3'h4)
    else $error("bad power state");
  a_power_on_edge: assert property (
    $changed(powerState) |-> age_q inside {[4'h1:4'h8]})
    else $error("power change without link edge");
  a_low_cke_hold: assert property (
    low_q >= 4'hc && powerState != 3'h0 |=> $stable(powerState))
    else $error("power state left with clock enable low");
  a_deep_clears: assert property (deepHeld |-> !initDone)
    else $error("initDone kept in deep sleep");
  a_burst_single: assert property (!(readBurst && writeBurst))
    else $error("read and write burst together");
  a_ready_normal: assert property (
    $rose(initDone) |-> powerState == 3'h0)
    else $error("ready outside normal state");
endmodule : lpd_top_sva
bind lpd_top lpd_top_sva chk (.core_clk, .rst, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .memPins, .powerState,
  .readBurst, .writeBurst, .initDone);

/* testbench/lpd_ctl_model.sv */
// Behavioural memory controller driving the command pins
`timescale 1ns/1ps
module lpd_ctl_model (
  input  wire logic          core_clk,
  output lpd_pkg::lpd_pins_t memPins
);
  initial memPins = 21'h0fffff;
  // Link clock runs only inside a frame, eight core cycles per half
  task automatic send(input logic ck, input logic [3:0] c,
                      input logic [1:0] b, input logic [12:0] a,
                      input int n);
    // Spare edge keeps this drive apart from the last frame's release
    @(posedge core_clk);
    memPins.cke <= ck;
    {memPins.csN, memPins.rasN, memPins.casN, memPins.weN} <= c;
    memPins.ba <= b;
    memPins.addr <= a;
    repeat (n)
    begin
      repeat (8) @(posedge core_clk);
      memPins.memClk <= 1'b1;
      repeat (8) @(posedge core_clk);
      memPins.memClk <= 1'b0;
      // Deselect after the command; idle lines must not keep old levels
      memPins.csN <= 1'b1;
      memPins[17:0] <= ~memPins[17:0];
    end
  endtask : send
  task automatic initSeq();
    send(1'b1, 4'h7, 2'h0, 13'h0, 1250);
    send(1'b1, 4'h2, 2'h0, 13'h0400, 2);
    repeat (2) send(1'b1, 4'h1, 2'h0, 13'h0, 3);
    send(1'b1, 4'h0, 2'h0, 13'h0022, 2);
    send(1'b1, 4'h0, 2'h2, 13'h0000, 2);
  endtask : initSeq
endmodule : lpd_ctl_model

/* testbench/lpd_top_bench.sv */
// Self-checking bench for lpd_top
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module lpd_top_bench;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, AREF = 4'h1, LMR = 4'h0;
  typedef struct {logic [1:0] b; logic [12:0] a; logic [31:0] s, x, t;}
    lpd_mrow_t;
  typedef struct {logic ck; logic [3:0] c; logic [1:0] b; logic [2:0] st;}
    lpd_prow_t;
  logic               core_clk = 1'b0;
  logic               rst = 1'b1;
  logic               hsel = 1'b0;
  logic               hwrite = 1'b0;
  logic [1:0]         htrans = 2'h0;
  logic [31:0]        haddr = 32'h0;
  logic [31:0]        hwdata = 32'h0;
  logic [31:0]        hrdata;
  logic [31:0]        rdv;
  logic               hreadyout;
  logic               hresp;
  logic               readBurst;
  logic               writeBurst;
  logic               initDone;
  logic [2:0]         powerState;
  lpd_pkg::lpd_pins_t memPins;
  int                 badCount = 0;
  int                 nCompared = 0;
  int                 rdCnt = 0;
  int                 wrCnt = 0;
  lpd_mrow_t modes [6] = '{
    '{2'h0, 13'h021, 32'h21, 32'h0, 32'h201},
    '{2'h0, 13'h03a, 32'h3a, 32'h0, 32'h1302},
    '{2'h0, 13'h023, 32'h23, 32'h0, 32'h204},
    '{2'h0, 13'h034, 32'h34, 32'h0, 32'h308},
    '{2'h2, 13'h055, 32'h34, 32'h55, 32'h308},
    '{2'h1, 13'h022, 32'h34, 32'h55, 32'h308}};
  lpd_prow_t steps [8] = '{'{1'b0, NOP, 2'h0, 3'h2},
    '{1'b0, ACT, 2'h0, 3'h2}, '{1'b1, NOP, 2'h0, 3'h0},
    '{1'b0, AREF, 2'h0, 3'h3}, '{1'b1, NOP, 2'h0, 3'h0},
    '{1'b1, ACT, 2'h1, 3'h0}, '{1'b0, NOP, 2'h0, 3'h1},
    '{1'b1, NOP, 2'h0, 3'h0}};
  lpd_ctl_model ctl (.core_clk(core_clk), .memPins(memPins));
  lpd_top uut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .memPins, .powerState, .readBurst, .writeBurst, .initDone);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    rdCnt += int'(readBurst);
    wrCnt += int'(writeBurst);
  end
  task automatic completeRun();
    if (badCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : completeRun
  task automatic waitReady();
    int i;
    i = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 50)
      begin
        badCount++;
        completeRun();
      end
      @(posedge core_clk);
    end
  endtask : waitReady
  // Entered just after a clock edge; returns just after the data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rdv = hrdata;
  endtask : xfer
  task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdv, e)
  endtask : chkReg
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chkReg(lpd_pkg::ADDR_STATUS, 32'h0);
    chkReg(lpd_pkg::ADDR_STD_MODE, 32'h0);
    chkReg(lpd_pkg::ADDR_EXT_MODE, 32'h0);
    chkReg(lpd_pkg::ADDR_CONTROL, 32'h1);
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    chkReg(8'h20, 32'h0);
    xfer(1'b1, lpd_pkg::ADDR_STATUS, 32'hffff_ffff);
    chkReg(lpd_pkg::ADDR_STATUS, 32'h0);
    xfer(1'b1, lpd_pkg::ADDR_CONTROL, 32'h0000_0f01);
    chkReg(lpd_pkg::ADDR_CONTROL, 32'h0000_0f01);
    ctl.initSeq();
    @(posedge core_clk);
    `CHK(initDone, 1'b1)
    foreach (modes[i])
    begin
      ctl.send(1'b1, LMR, modes[i].b, modes[i].a, 2);
      @(posedge core_clk);
      chkReg(lpd_pkg::ADDR_STD_MODE, modes[i].s);
      chkReg(lpd_pkg::ADDR_EXT_MODE, modes[i].x);
      chkReg(lpd_pkg::ADDR_TIMING, modes[i].t);
    end
    xfer(1'b1, lpd_pkg::ADDR_CONTROL, 32'h0);
    ctl.send(1'b1, LMR, 2'h0, 13'h021, 2);
    @(posedge core_clk);
    chkReg(lpd_pkg::ADDR_STD_MODE, 32'h34);
    xfer(1'b1, lpd_pkg::ADDR_CONTROL, 32'h1);
    foreach (steps[i])
    begin
      ctl.send(steps[i].ck, steps[i].c, steps[i].b, 13'h0, 3);
      @(posedge core_clk);
      `CHK(powerState, steps[i].st)
    end
    chkReg(lpd_pkg::ADDR_STATUS, 32'h420);
    rdCnt = 0;
    wrCnt = 0;
    // Sixteen-beat bursts span eight link periods of sixteen cycles
    ctl.send(1'b1, RD, 2'h1, 13'h0, 14);
    ctl.send(1'b1, WR, 2'h1, 13'h0400, 11);
    @(posedge core_clk);
    `CHK(rdCnt, 128)
    `CHK(wrCnt, 128)
    chkReg(lpd_pkg::ADDR_STATUS, 32'h400);
    ctl.send(1'b0, BST, 2'h0, 13'h0, 2);
    @(posedge core_clk);
    `CHK(powerState, lpd_pkg::PW_DEEPEST_SLEEP_STATE)
    `CHK(initDone, 1'b0)
    chkReg(lpd_pkg::ADDR_STD_MODE, 32'h0);
    ctl.send(1'b1, NOP, 2'h0, 13'h0, 3);
    ctl.initSeq();
    @(posedge core_clk);
    `CHK(initDone, 1'b1)
    completeRun();
  end
endmodule : lpd_top_bench
